// ==== cwd_core.v ====
// Standby, shadow write, exclusive-or and opcode decode slice
//
// Notes on behaviour
// - Standby needs system control access, else unusable
// - Enabled interrupt on wake: return PC plus 4
// - Pending test: priority compare or pending-and-mask
// - Enabled needs enable set, no exception/error/debug
// - Shadow write copies rt into previous set
// - Before release 2, shadow write, swap reserved
// - Byte swap exchanges bytes in each halfword
// - Register exclusive-or, no exception
// - Zero-extended immediate exclusive-or, no exception
// - Opcode first, classes resolved by other fields
// - Opcode is bits 31..29 then 28..26
// - Reserved encodings trap; unusable coprocessor first
// - Every release: unassigned encodings trap unless i_known is set
// - Higher level encodings trap as reserved
// - Release 6 wakes on any interrupt; code zero keeps counter
// - Release 6: standby in a slot traps
`timescale 1ns/100ps
`include "cwd_map.vh"
module cwd_core #(
	parameter SSW = 4
) (
	input  wire           i_mclk,
	input  wire           i_rstn,
	input  wire [7:0]     i_addr,
	input  wire [31:0]    i_wdata,
	input  wire           i_wr,
	input  wire           i_rd,
	output reg  [31:0]    o_rdata,
	output wire           o_irq,
	input  wire           i_valid,
	input  wire [31:0]    i_instr,
	input  wire [31:0]    i_pc,
	input  wire [31:0]    i_rs_val,
	input  wire [31:0]    i_rt_val,
	input  wire           i_in_slot,
	input  wire           i_known,
	input  wire [3:0]     i_cop_usable,
	input  wire           i_external_controller_present,
	input  wire [4:0]     i_vector_spacing,
	input  wire           i_special_vector_select,
	input  wire           i_boot_exception_vectors,
	input  wire [5:0]     i_requested_priority_level,
	input  wire [5:0]     i_current_priority_level,
	input  wire [7:0]     i_pending_interrupt_bits,
	input  wire [7:0]     i_interrupt_mask_bits,
	input  wire           i_global_interrupt_enable,
	input  wire           i_exception_level,
	input  wire           i_error_level,
	input  wire           i_debug_mode_flag,
	input  wire [SSW-1:0] i_previous_shadow_set,
	input  wire           i_wake_event,
	input  wire           i_reset_req,
	input  wire           i_nmi,
	output wire           o_stall,
	output reg            o_standby,
	output reg            o_count_hold,
	output reg            o_wb_en,
	output reg  [4:0]     o_wb_reg,
	output reg  [31:0]    o_wb_data,
	output reg            o_exc_ri,
	output reg            o_exc_cpu,
	output reg  [1:0]     o_exc_cop,
	output reg            o_take_int,
	output reg            o_take_nmi,
	output reg            o_take_reset,
	output reg            o_resume,
	output reg  [31:0]    o_exception_return_pc,
	output reg  [31:0]    o_next_pc
);
	localparam ST_RUN   = 1'b0;
	localparam ST_SLEEP = 1'b1;
	localparam C_NONE = 3'h0;
	localparam C_XOR  = 3'h1;
	localparam C_EXCLUSIVE_OR_IMMEDIATE = 3'h2;
	localparam C_WSBH = 3'h3;
	localparam C_WRPS = 3'h4;
	localparam C_WAIT = 3'h5;
	localparam C_HIGH = 3'h6;
	localparam C_PASS = 3'h7;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function [2:0] cwd_class;
		input [31:0] w;
		reg   [5:0]  op;
		begin
			op = {w[31:29], w[28:26]};
			case (op)
				`CWD_OP_SPECIAL:
					cwd_class = (w[5:0] == `CWD_FN_XOR && w[10:6] == 5'h00) ? C_XOR : C_NONE;
				`CWD_OP_EXCLUSIVE_OR_IMMEDIATE:
					cwd_class = C_EXCLUSIVE_OR_IMMEDIATE;
				`CWD_OP_SPECIAL3:
					cwd_class = (w[5:0] == `CWD_FN_BSHFL && w[10:6] == `CWD_SA_WSBH) ? C_WSBH : C_NONE;
				`CWD_OP_SYSTEM_CONTROL_COPROCESSOR: begin
					if (w[25] && w[5:0] == `CWD_FN_WAIT)
						cwd_class = C_WAIT;
					else if (w[25:21] == `CWD_RS_WRITE_PREVIOUS_SHADOW_REGISTER && w[10:0] == 11'h000)
						cwd_class = C_WRPS;
					else
						cwd_class = C_NONE;
				end
				// Register-immediate class is resolved by rt in the branch decoder
				`CWD_OP_REGISTER_IMMEDIATE_CLASS:
					cwd_class = C_PASS;
				// Doubleword loads, stores and arithmetic belong to a wider level
				6'h18, 6'h19, 6'h1a, 6'h1b, 6'h27, 6'h34, 6'h37, 6'h3c, 6'h3f:
					cwd_class = C_HIGH;
				default:
					cwd_class = C_NONE;
			endcase
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [3:0]  ctrl_q;
	reg  [`CWD_EV_W-1:0] istat_q;
	reg  [`CWD_EV_W-1:0] imask_q;
	reg  [SSW+4:0] ssel_q;
	reg         state_q;
	reg  [31:0] wpc_q;
	reg  [19:0] code_q;
	reg         sdata_q;
	reg  [31:0] rd_q;

	// Release level gates the shadow write, the swap and the slot check
	wire [2:0]  rel  = ctrl_q[`CWD_CTRL_REL_MSB:0];
	wire        rel6 = rel >= `CWD_REL_FULL;
	wire [2:0]  cls  = cwd_class(i_instr);
	wire [5:0]  op   = {i_instr[31:29], i_instr[28:26]};
	wire        is_cop = op[5:2] == 4'h4;

	// Coprocessor unusable is checked ahead of any reserved test
	wire cpu_exc = i_valid && is_cop && !i_cop_usable[op[1:0]];
	wire early   = rel < `CWD_REL_SHADOW;
	wire ri_exc  = i_valid && !cpu_exc && (
		cls == C_HIGH ||
		((cls == C_WRPS || cls == C_WSBH) && early) ||
		(cls == C_WAIT && rel6 && i_in_slot) ||
		(cls == C_NONE && !i_known));
	wire good    = i_valid && !cpu_exc && !ri_exc;
	wire go_wait = good && cls == C_WAIT && state_q == ST_RUN;

	// ----------------------------------------
	// Interrupt qualification
	// ----------------------------------------
	// Priority compare only in vectored external-controller mode
	wire veic = i_external_controller_present && (i_vector_spacing != 5'h00) &&
		i_special_vector_select && !i_boot_exception_vectors;
	wire unmasked = veic ?
		(i_requested_priority_level > i_current_priority_level) :
		|(i_pending_interrupt_bits & i_interrupt_mask_bits);
	wire enabled = i_global_interrupt_enable && !i_exception_level &&
		!i_error_level && !i_debug_mode_flag;
	// Later releases wake on any arrival, enabled or masked
	wire any_int = (|i_pending_interrupt_bits) || (i_requested_priority_level != 6'h00);
	wire wake = unmasked || i_wake_event || (rel6 && any_int) ||
		i_reset_req || i_nmi;
	wire leave = state_q == ST_SLEEP && wake;

	// Stall drops in the wake cycle so the pipeline restarts without a lost cycle
	assign o_stall = go_wait || (state_q == ST_SLEEP && !leave);

	// ----------------------------------------
	// Standby sequencing
	// ----------------------------------------
	always @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= ST_RUN;
			wpc_q <= 32'h00000000;
			code_q <= 20'h00000;
			o_standby <= 1'b0;
			o_count_hold <= 1'b0;
			o_take_int <= 1'b0;
			o_take_nmi <= 1'b0;
			o_take_reset <= 1'b0;
			o_resume <= 1'b0;
			o_exception_return_pc <= 32'h00000000;
			o_next_pc <= 32'h00000000;
		end else begin
			o_take_int <= 1'b0;
			o_take_nmi <= 1'b0;
			o_take_reset <= 1'b0;
			o_resume <= 1'b0;
			case (state_q)
				ST_RUN: begin
					if (go_wait) begin
						state_q <= ST_SLEEP;
						wpc_q <= i_pc;
						// Code field is kept for software to read back while asleep
						code_q <= i_instr[25:6];
						o_standby <= 1'b1;
						// The default code never stops the cycle counter
						o_count_hold <= ctrl_q[`CWD_CTRL_CSTOP] && i_instr[24:6] != 19'h00000;
					end
				end
				ST_SLEEP: begin
					if (leave) begin
						state_q <= ST_RUN;
						o_standby <= 1'b0;
						o_count_hold <= 1'b0;
						// Reset outranks the non-maskable interrupt, which outranks the rest
						if (i_reset_req) begin
							o_take_reset <= 1'b1;
						end else if (i_nmi) begin
							o_take_nmi <= 1'b1;
						end else if (unmasked && enabled) begin
							o_take_int <= 1'b1;
							o_exception_return_pc <= wpc_q + `CWD_PC_STEP;
						end else begin
							o_resume <= 1'b1;
							o_next_pc <= wpc_q + `CWD_PC_STEP;
						end
					end
				end
				default: begin
					state_q <= ST_RUN;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Result write-back and exceptions
	// ----------------------------------------
	wire [31:0] alu_res;
	wire [1:0]  alu_sel = (cls == C_EXCLUSIVE_OR_IMMEDIATE) ? 2'h1 : (cls == C_WSBH) ? 2'h2 : 2'h0;

	cwd_logic_unit u_alu (
		.i_sel (alu_sel),
		.i_rs  (i_rs_val),
		.i_rt  (i_rt_val),
		.i_imm (i_instr[15:0]),
		.o_res (alu_res)
	);

	wire alu_op = cls == C_XOR || cls == C_EXCLUSIVE_OR_IMMEDIATE || cls == C_WSBH;

	always @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_wb_en <= 1'b0;
			o_wb_reg <= 5'h00;
			o_wb_data <= 32'h00000000;
			o_exc_ri <= 1'b0;
			o_exc_cpu <= 1'b0;
			o_exc_cop <= 2'h0;
		end else begin
			// Pulses last one cycle; the pipeline must take them at once
			o_wb_en <= good && alu_op;
			o_wb_reg <= (cls == C_EXCLUSIVE_OR_IMMEDIATE) ? i_instr[20:16] : i_instr[15:11];
			o_wb_data <= alu_res;
			o_exc_ri <= ri_exc;
			o_exc_cpu <= cpu_exc;
			o_exc_cop <= op[1:0];
		end
	end

	// ----------------------------------------
	// Previous shadow set storage
	// ----------------------------------------
	wire [31:0] sh_rdata;
	wire        sh_we = good && cls == C_WRPS;

	cwd_shadow_ram #(
		.AW (SSW + 5),
		.DW (32)
	) u_shadow (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_we    (sh_we),
		.i_waddr ({i_previous_shadow_set, i_instr[15:11]}),
		.i_wdata (i_rt_val),
		.i_raddr (ssel_q),
		.o_rdata (sh_rdata)
	);

	// ----------------------------------------
	// Register port and interrupt
	// ----------------------------------------
	wire [`CWD_EV_W-1:0] ev;
	assign ev[`CWD_EV_RI] = ri_exc;
	assign ev[`CWD_EV_CPU] = cpu_exc;
	assign ev[`CWD_EV_WAKE] = leave;
	assign ev[`CWD_EV_SLEEP] = go_wait;

	// Write one to clear; bits written as zero are left alone
	wire [`CWD_EV_W-1:0] clr = (i_wr && i_addr == `CWD_REG_ISTAT) ? i_wdata[`CWD_EV_W-1:0] : {`CWD_EV_W{1'b0}};

	// Level output, high until software clears or masks the cause
	assign o_irq = |(istat_q & imask_q);

	always @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctrl_q <= `CWD_CTRL_RST;
			istat_q <= {`CWD_EV_W{1'b0}};
			imask_q <= {`CWD_EV_W{1'b0}};
			ssel_q <= {(SSW+5){1'b0}};
		end else begin
			// A new event wins over a clear in the same cycle
			istat_q <= (istat_q & ~clr) | ev;
			if (i_wr) begin
				case (i_addr)
					`CWD_REG_CTRL: ctrl_q <= i_wdata[3:0];
					`CWD_REG_IMASK: imask_q <= i_wdata[`CWD_EV_W-1:0];
					`CWD_REG_SSEL: ssel_q <= i_wdata[SSW+4:0];
					default: ;
				endcase
			end
		end
	end

	// Shadow data arrives from the memory register, so it is chosen after the read
	always @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_q <= 32'h00000000;
			sdata_q <= 1'b0;
		end else begin
			sdata_q <= i_rd && i_addr == `CWD_REG_SDATA;
			rd_q <= 32'h00000000;
			if (i_rd) begin
				case (i_addr)
					`CWD_REG_CTRL: rd_q <= {28'h0000000, ctrl_q};
					`CWD_REG_STAT: rd_q <= {code_q, 11'h000, state_q};
					`CWD_REG_ISTAT: rd_q <= {28'h0000000, istat_q};
					`CWD_REG_IMASK: rd_q <= {28'h0000000, imask_q};
					`CWD_REG_SSEL: rd_q <= {{(27-SSW){1'b0}}, ssel_q};
					default: rd_q <= 32'h00000000;
				endcase
			end
		end
	end

	always @* begin
		o_rdata = sdata_q ? sh_rdata : rd_q;
	end
endmodule

// ==== cwd_map.vh ====
// Constants for the standby and decode slice
`ifndef CWD_MAP_VH
`define CWD_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CWD_REG_CTRL 8'h00
`define CWD_REG_STAT 8'h04
`define CWD_REG_ISTAT 8'h08
`define CWD_REG_IMASK 8'h0c
`define CWD_REG_SSEL 8'h10
`define CWD_REG_SDATA 8'h14
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define CWD_CTRL_REL_MSB 2
`define CWD_CTRL_CSTOP 3
`define CWD_CTRL_RST 4'h6
`define CWD_EV_RI 0
`define CWD_EV_CPU 1
`define CWD_EV_WAKE 2
`define CWD_EV_SLEEP 3
`define CWD_EV_W 4
`define CWD_REL_SHADOW 3'h2
`define CWD_REL_FULL 3'h6
// ----------------------------------------
// Encodings
// ----------------------------------------
`define CWD_OP_SPECIAL 6'h00
`define CWD_OP_REGISTER_IMMEDIATE_CLASS 6'h01
`define CWD_OP_EXCLUSIVE_OR_IMMEDIATE 6'h0e
`define CWD_OP_SYSTEM_CONTROL_COPROCESSOR 6'h10
`define CWD_OP_SPECIAL3 6'h1f
`define CWD_FN_XOR 6'h26
`define CWD_FN_WAIT 6'h20
`define CWD_FN_BSHFL 6'h20
`define CWD_SA_WSBH 5'h02
`define CWD_RS_WRITE_PREVIOUS_SHADOW_REGISTER 5'h0e
`define CWD_PC_STEP 32'h00000004
`endif

// ==== cwd_shadow_ram.v ====
// Shadow register set storage with registered read data
`timescale 1ns/100ps
module cwd_shadow_ram #(
	parameter AW = 9,
	parameter DW = 32
) (
	input  wire          i_mclk,
	input  wire          i_rstn,
	input  wire          i_we,
	input  wire [AW-1:0] i_waddr,
	input  wire [DW-1:0] i_wdata,
	input  wire [AW-1:0] i_raddr,
	output reg  [DW-1:0] o_rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge i_mclk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= {DW{1'b0}};
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end
endmodule

// ==== cwd_logic_unit.v ====
// Result datapath for exclusive-or and halfword byte swap
`timescale 1ns/100ps
module cwd_logic_unit (
	input  wire [1:0]  i_sel,
	input  wire [31:0] i_rs,
	input  wire [31:0] i_rt,
	input  wire [15:0] i_imm,
	output reg  [31:0] o_res
);
	always @* begin
		case (i_sel)
			2'h0: o_res = i_rs ^ i_rt;
			2'h1: o_res = i_rs ^ {16'h0000, i_imm};
			2'h2: o_res = {i_rt[23:16], i_rt[31:24], i_rt[7:0], i_rt[15:8]};
			default: o_res = i_rt;
		endcase
	end
endmodule

// ==== cwd_core_properties.sv ====
// Assertions for the standby and decode slice
`timescale 1ns/100ps
module cwd_core_properties (
	input wire        i_mclk,
	input wire        i_rstn,
	input wire        i_valid,
	input wire [31:0] i_instr,
	input wire [31:0] i_pc,
	input wire [31:0] i_rs_val,
	input wire [31:0] i_rt_val,
	input wire        i_in_slot,
	input wire [3:0]  i_cop_usable,
	input wire [7:0]  i_pending_interrupt_bits,
	input wire        i_wake_event,
	input wire        i_reset_req,
	input wire        i_nmi,
	input wire        o_stall,
	input wire        o_standby,
	input wire        o_count_hold,
	input wire        o_wb_en,
	input wire [31:0] o_wb_data,
	input wire        o_exc_ri,
	input wire        o_exc_cpu,
	input wire        o_take_nmi,
	input wire        o_take_reset,
	input wire        o_resume,
	input wire [31:0] o_next_pc
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	wire [5:0] op = i_instr[31:26];
	wire go = i_valid && !o_standby;
	wire wai = go && op == 6'h10 && i_instr[25] && i_instr[5:0] == 6'h20;
	logic [31:0] res_q;
	logic [31:0] wpc_q;
	// Expected result kept one cycle so it lines up with the write-back
	always @(posedge i_mclk) begin
		res_q <= i_rs_val ^ (op == 6'h0e ? {16'h0000, i_instr[15:0]} : i_rt_val);
		if (wai)
			wpc_q <= i_pc;
	end
	sequence s_sleep; o_stall ##1 o_standby; endsequence
	sequence s_nmi; !o_stall ##1 (o_take_nmi && !o_standby); endsequence
	sequence s_rst; !o_stall ##1 (o_take_reset && !o_standby); endsequence
	property p_rst; o_standby && i_reset_req |-> s_rst; endproperty
	property p_hold0; wai && i_instr[24:6] == 19'h00000 |=> !o_count_hold; endproperty
	property p_xor; go && op == 0 && i_instr[10:0] == 11'h026 |=> o_wb_en && o_wb_data == res_q && !o_exc_ri; endproperty
	property p_exclusive_or_immediate; go && op == 6'h0e |=> o_wb_en && o_wb_data == res_q && !o_exc_ri && !o_exc_cpu; endproperty
	property p_rsv; go && op == 6'h18 |=> o_exc_ri && !o_wb_en; endproperty
	property p_cpu; go && op[5:2] == 4'b0100 && !i_cop_usable[op[1:0]] |=> o_exc_cpu && !o_exc_ri; endproperty
	property p_enter; wai && i_cop_usable[0] && !i_in_slot |-> s_sleep; endproperty
	property p_wcpu; wai && !i_cop_usable[0] |=> o_exc_cpu && !o_standby; endproperty
	property p_nmi; o_standby && i_nmi && !i_reset_req |-> s_nmi; endproperty
	property p_resume;
		o_standby && i_wake_event && i_pending_interrupt_bits == 0 && !i_nmi && !i_reset_req
			|=> o_resume && o_next_pc == wpc_q + 32'h4;
	endproperty
	a_xor: assert property (p_xor) else $error("register xor result wrong");
	a_exclusive_or_immediate: assert property (p_exclusive_or_immediate) else $error("immediate xor result wrong");
	a_rsv: assert property (p_rsv) else $error("reserved opcode not trapped");
	a_cpu: assert property (p_cpu) else $error("unusable not first");
	a_enter: assert property (p_enter) else $error("standby not entered");
	a_wcpu: assert property (p_wcpu) else $error("standby without access");
	a_nmi: assert property (p_nmi) else $error("nmi did not end standby");
	a_resume: assert property (p_resume) else $error("resume pc wrong");
	a_rst: assert property (p_rst) else $error("reset request did not end standby");
	a_hold0: assert property (p_hold0) else $error("default code stopped the counter");
endmodule

// ==== cwd_pipe_model.sv ====
// Register file of the surrounding pipeline
`timescale 1ns/100ps
module cwd_pipe_model (
	input  wire        i_mclk,
	input  wire [31:0] i_instr,
	input  wire        i_wb_en,
	input  wire [4:0]  i_wb_reg,
	input  wire [31:0] i_wb_data,
	output wire [31:0] o_rs_val,
	output wire [31:0] o_rt_val
);
	logic [31:0] gpr [0:31];
	// Operands come straight from the fields, as a bypass-free pipeline would
	assign o_rs_val = gpr[i_instr[25:21]];
	assign o_rt_val = gpr[i_instr[20:16]];
	always @(posedge i_mclk) begin
		if (i_wb_en)
			gpr[i_wb_reg] <= i_wb_data;
	end
endmodule

// ==== cwd_core_tb.sv ====
// Self-checking bench for the standby and decode slice
`timescale 1ns/100ps
`include "cwd_map.vh"
module cwd_core_tb;
	logic        i_mclk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, i_valid = 0, i_in_slot = 0, i_known = 0;
	logic        i_external_controller_present = 0, i_special_vector_select = 0, i_boot_exception_vectors = 0;
	logic        i_global_interrupt_enable = 0, i_exception_level = 0, i_error_level = 0, i_debug_mode_flag = 0;
	logic        i_wake_event = 0, i_reset_req = 0, i_nmi = 0;
	logic [7:0]  i_addr = 0, i_pending_interrupt_bits = 0, i_interrupt_mask_bits = 0;
	logic [31:0] i_wdata = 0, i_instr = 0, i_pc = 0;
	logic [3:0]  i_cop_usable = 4'hf, i_previous_shadow_set = 0;
	logic [4:0]  i_vector_spacing = 0;
	logic [5:0]  i_requested_priority_level = 0, i_current_priority_level = 0;
	wire  [31:0] i_rs_val, i_rt_val, o_rdata, o_wb_data, o_exception_return_pc, o_next_pc;
	wire  [4:0]  o_wb_reg;
	wire  [1:0]  o_exc_cop;
	wire         o_irq, o_stall, o_standby, o_count_hold, o_wb_en, o_exc_ri, o_exc_cpu;
	wire         o_take_int, o_take_nmi, o_take_reset, o_resume;
	int          bad_count = 0;
	int          checks = 0;
	logic [5:0]  rpl = 0;
	localparam logic [31:0] WAI = 32'h42000020;
	localparam logic [31:0] SWP = {6'h1f, 5'd0, 5'd2, 5'd5, 5'h02, 6'h20};
	localparam logic [31:0] SHW = {6'h10, 5'h0e, 5'd2, 5'd7, 11'h000};
	always #10 i_mclk = ~i_mclk;
	cwd_core uut (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_irq(o_irq), .i_valid(i_valid), .i_instr(i_instr), .i_pc(i_pc),
		.i_rs_val(i_rs_val), .i_rt_val(i_rt_val), .i_in_slot(i_in_slot), .i_known(i_known),
		.i_cop_usable(i_cop_usable), .i_external_controller_present(i_external_controller_present),
		.i_vector_spacing(i_vector_spacing), .i_special_vector_select(i_special_vector_select),
		.i_boot_exception_vectors(i_boot_exception_vectors),
		.i_requested_priority_level(i_requested_priority_level),
		.i_current_priority_level(i_current_priority_level),
		.i_pending_interrupt_bits(i_pending_interrupt_bits), .i_interrupt_mask_bits(i_interrupt_mask_bits),
		.i_global_interrupt_enable(i_global_interrupt_enable), .i_exception_level(i_exception_level),
		.i_error_level(i_error_level), .i_debug_mode_flag(i_debug_mode_flag),
		.i_previous_shadow_set(i_previous_shadow_set), .i_wake_event(i_wake_event),
		.i_reset_req(i_reset_req), .i_nmi(i_nmi), .o_stall(o_stall), .o_standby(o_standby),
		.o_count_hold(o_count_hold), .o_wb_en(o_wb_en), .o_wb_reg(o_wb_reg), .o_wb_data(o_wb_data),
		.o_exc_ri(o_exc_ri), .o_exc_cpu(o_exc_cpu), .o_exc_cop(o_exc_cop), .o_take_int(o_take_int),
		.o_take_nmi(o_take_nmi), .o_take_reset(o_take_reset), .o_resume(o_resume),
		.o_exception_return_pc(o_exception_return_pc), .o_next_pc(o_next_pc)
	);
	cwd_pipe_model m (
		.i_mclk(i_mclk), .i_instr(i_instr), .i_wb_en(o_wb_en), .i_wb_reg(o_wb_reg), .i_wb_data(o_wb_data),
		.o_rs_val(i_rs_val), .o_rt_val(i_rt_val)
	);
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic chk(input [31:0] got, input [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1;
		@(posedge i_mclk);
		i_wr <= 0;
	endtask
	task automatic rd(input [7:0] a, input [31:0] e);
		i_addr <= a;
		i_rd <= 1;
		@(posedge i_mclk);
		i_rd <= 0;
		@(negedge i_mclk);
		chk(o_rdata, e);
		@(posedge i_mclk);
	endtask
	// Ends at the falling edge of the answer cycle
	task automatic ex(input [31:0] w);
		i_instr <= w;
		i_valid <= 1;
		@(posedge i_mclk);
		i_valid <= 0;
		@(negedge i_mclk);
	endtask
	task automatic xc(input [31:0] w, input [4:0] r, input [31:0] e);
		ex(w);
		@(negedge i_mclk);
		chk(m.gpr[r], e);
		@(posedge i_mclk);
	endtask
	task automatic ev(input [31:0] w, input [31:0] e);
		ex(w);
		chk({o_exc_cpu, o_exc_ri}, e[1:0]);
		@(posedge i_mclk);
		rd(`CWD_REG_ISTAT, e);
		wr(`CWD_REG_ISTAT, 32'hf);
	endtask
	task automatic wt(input [7:0] p, input [7:0] k, input [4:0] s, input [3:0] e, input [18:0] c, input h);
		int n;
		i_pc <= i_pc + 32'h40;
		ex(WAI | {7'h00, c, 6'h00});
		chk(o_standby, 1);
		chk(o_count_hold, h);
		@(posedge i_mclk);
		rd(`CWD_REG_STAT, {1'b1, c, 11'h000, 1'b1});
		i_pending_interrupt_bits <= p;
		i_interrupt_mask_bits <= k;
		i_requested_priority_level <= rpl;
		{i_reset_req, i_nmi, i_wake_event, i_exception_level, i_global_interrupt_enable} <= s;
		n = 0;
		do begin
			@(negedge i_mclk);
			n++;
		end while (n < 20 && {o_take_int, o_resume, o_take_nmi, o_take_reset} === 4'h0);
		chk({o_take_int, o_resume, o_take_nmi, o_take_reset}, e);
		if (e[3] || e[2])
			chk(e[3] ? o_exception_return_pc : o_next_pc, i_pc + 32'h4);
		if (n == 20)
			summarize();
		@(posedge i_mclk);
		{i_reset_req, i_nmi, i_wake_event, i_exception_level, i_global_interrupt_enable} <= 0;
		i_pending_interrupt_bits <= 0;
		i_requested_priority_level <= 0;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		m.gpr[1] = 32'hf0f0_1234;
		m.gpr[2] = 32'h0ff0_a5c3;
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1;
		@(posedge i_mclk);
		rd(`CWD_REG_CTRL, `CWD_CTRL_RST);
		rd(8'h40, 0);
		xc({6'h00, 5'd1, 5'd2, 5'd3, 5'd0, 6'h26}, 3, 32'hff00_b7f7);
		xc({6'h0e, 5'd1, 5'd4, 16'h8001}, 4, 32'hf0f0_9235);
		xc(SWP, 5, 32'hf00f_c3a5);
		i_previous_shadow_set <= 3;
		ex(SHW);
		@(posedge i_mclk);
		wr(`CWD_REG_SSEL, 32'h67);
		repeat (2) @(posedge i_mclk);
		rd(`CWD_REG_SDATA, 32'h0ff0_a5c3);
		ev(32'h60000000, 1);
		ev(32'h70000000, 1);
		i_known <= 1;
		ev(32'h70000000, 0);
		i_known <= 0;
		ev(32'h04000000, 0);
		i_cop_usable <= 4'h3;
		ev(32'h48000000, 2);
		@(negedge i_mclk);
		chk(o_exc_cop, 2);
		@(posedge i_mclk);
		i_cop_usable <= 4'he;
		ev(WAI, 2);
		i_cop_usable <= 4'hf;
		i_in_slot <= 1;
		ev(WAI, 1);
		i_in_slot <= 0;
		wr(`CWD_REG_CTRL, 1);
		ev(SHW, 1);
		ex(SWP);
		@(negedge i_mclk);
		chk(o_irq, 0);
		@(posedge i_mclk);
		wr(`CWD_REG_IMASK, 1);
		@(negedge i_mclk);
		chk(o_irq, 1);
		@(posedge i_mclk);
		wr(`CWD_REG_ISTAT, 1);
		@(negedge i_mclk);
		chk(o_irq, 0);
		@(posedge i_mclk);
		wr(`CWD_REG_CTRL, 6);
		wt(2, 2, 5'b00001, 4'b1000, 0, 0);
		wt(2, 2, 5'b00011, 4'b0100, 0, 0);
		i_error_level <= 1;
		wt(2, 2, 5'b00001, 4'b0100, 0, 0);
		{i_error_level, i_debug_mode_flag} <= 2'b01;
		wt(2, 2, 5'b00001, 4'b0100, 0, 0);
		i_debug_mode_flag <= 0;
		wt(1, 0, 5'b00001, 4'b0100, 0, 0);
		wt(0, 0, 5'b00100, 4'b0100, 0, 0);
		wt(0, 0, 5'b01000, 4'b0010, 0, 0);
		wt(0, 0, 5'b10000, 4'b0001, 0, 0);
		wr(`CWD_REG_CTRL, 32'he);
		wt(0, 0, 5'b00100, 4'b0100, 19'h00005, 1);
		wt(0, 0, 5'b00100, 4'b0100, 0, 0);
		{i_external_controller_present, i_special_vector_select} <= 2'b11;
		i_vector_spacing <= 5'h01;
		i_current_priority_level <= 6'h03;
		rpl = 6'h05;
		wt(0, 0, 5'b00001, 4'b1000, 0, 0);
		i_boot_exception_vectors <= 1;
		wt(0, 0, 5'b00001, 4'b0100, 0, 0);
		i_boot_exception_vectors <= 0;
		rpl = 6'h02;
		wt(0, 0, 5'b00001, 4'b0100, 0, 0);
		summarize();
	end
endmodule
bind cwd_core cwd_core_properties chk_i (
	.i_mclk(i_mclk), .i_rstn(i_rstn), .i_valid(i_valid), .i_instr(i_instr), .i_pc(i_pc),
	.i_rs_val(i_rs_val), .i_rt_val(i_rt_val), .i_in_slot(i_in_slot), .i_cop_usable(i_cop_usable),
	.i_pending_interrupt_bits(i_pending_interrupt_bits), .i_wake_event(i_wake_event),
	.i_reset_req(i_reset_req), .i_nmi(i_nmi), .o_stall(o_stall), .o_standby(o_standby),
	.o_count_hold(o_count_hold), .o_wb_en(o_wb_en), .o_wb_data(o_wb_data), .o_exc_ri(o_exc_ri),
	.o_exc_cpu(o_exc_cpu), .o_take_nmi(o_take_nmi), .o_take_reset(o_take_reset), .o_resume(o_resume),
	.o_next_pc(o_next_pc)
);
